/* inc/parallel_port_pkg.sv */
// Constants, types and register map for the parallel port group.
// ----------------------------------------------------------------
// How it works
// - A direction bit of one makes its pin an output, zero an input.
// - Every direction register clears to all zeros on reset.
// - Expanded or test operation: port C is the data bus, its registers unmapped.
// - Port C pin n carries external data bus bit n.
// - Single-chip or bootstrap operation: port C pins are inputs after reset.
// - Data registers are readable and writable while mapped and keep contents through reset.
// - Port D has six pins; its bits 7 and 6 read as zero.
// - Port D bits 0-1 serve the first async serial, bits 2-5 the first sync serial.
// - A port D data write never alters a pin owned by its alternate function.
// - Port D pins come out of reset as general-purpose inputs.
// - Port E is eight input-only pins, read-only, unaffected by reset.
// - Port E pin n is shared with analog input channel n.
// - Expanded or test operation: port F drives low address, registers unmapped.
// - Single-chip or bootstrap operation: ports F and B reset to inputs.
// - Port G bits carry serial, sync serial, backplane and read/write functions.
// - Port G pins 6-0 are inputs unless an alternate drives them; pin 7 drives read/write when expanded.
// ----------------------------------------------------------------
package parallel_port_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h04;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h02;
    localparam logic [7:0] IDX_PORT_F_DIRECTION = 8'h03;
    localparam logic [7:0] IDX_PORT_F_DATA = 8'h05;
    localparam logic [7:0] IDX_PORT_C_DATA = 8'h06;
    localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h07;
    localparam logic [7:0] IDX_PORT_D_DATA = 8'h08;
    localparam logic [7:0] IDX_PORT_D_DIRECTION = 8'h09;
    localparam logic [7:0] IDX_PORT_E_INPUT = 8'h0a;
    localparam logic [7:0] IDX_MODE_CONTROL = 8'h0b;

    localparam int ADDR_W = 8;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam int MODE_EXPANDED_BIT = 0;
    localparam logic [7:0] PORT_D_MASK = 8'h3f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef struct packed {
        logic [7:0] level;
        logic [7:0] enable;
    } pin_drive_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_RESP = 2'b10
    } rd_state_t;

endpackage

/* logic/parallel_port_group.sv */
// Parallel port group B to G with an AXI4-Lite register slave.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module parallel_port_group
    import parallel_port_pkg::*;
(
    input wire logic clock_in, // 50 MHz system clock
    input wire logic rst_b_in, // Asynchronous reset, active low
    // AXI4-Lite slave
    input wire logic awvalid_in, // Write address valid
    output logic awready_out, // Write address ready
    input wire logic [ADDR_W-1:0] awaddr_in, // Write byte address
    input wire logic wvalid_in, // Write data valid
    output logic wready_out, // Write data ready
    input wire logic [31:0] wdata_in, // Write data
    input wire logic [3:0] wstrb_in, // Write byte strobes
    output logic bvalid_out, // Write response valid
    input wire logic bready_in, // Write response ready
    output logic [1:0] bresp_out, // Write response code
    input wire logic arvalid_in, // Read address valid
    output logic arready_out, // Read address ready
    input wire logic [ADDR_W-1:0] araddr_in, // Read byte address
    output logic rvalid_out, // Read data valid
    input wire logic rready_in, // Read data ready
    output logic [31:0] rdata_out, // Read data
    output logic [1:0] rresp_out, // Read response code
    // External bus sources used in expanded operation
    input wire logic [15:0] ext_addr_in, // External address
    input wire logic [7:0] ext_wdata_in, // Data the core drives out
    input wire logic ext_data_drive_in, // High while the core drives the data bus
    input wire logic ext_rw_in, // Read/write strobe level
    output logic [7:0] ext_rdata_out, // Sampled data bus pins
    // Alternate functions on ports D and G
    input wire logic [5:0] d_alt_sel_in, // Port D pins owned by serial units
    input wire logic [5:0] d_alt_level_in, // Port D alternate output levels
    input wire logic [5:0] d_alt_enable_in, // Port D alternate output enables
    input wire logic [6:0] g_alt_sel_in, // Port G pins owned by alternates
    input wire logic [6:0] g_alt_level_in, // Port G alternate output levels
    input wire logic [6:0] g_alt_enable_in, // Port G alternate output enables
    output logic [7:0] pin_level_out, // Sampled pin levels, port D then G
    // Pins
    input wire logic [7:0] port_b_pin_in, // Port B pin levels
    output pin_drive_t port_b_pin_out, // Port B drive and enable
    input wire logic [7:0] port_c_pin_in, // Port C pin levels
    output pin_drive_t port_c_pin_out, // Port C drive and enable
    input wire logic [5:0] port_d_pin_in, // Port D pin levels
    output pin_drive_t port_d_pin_out, // Port D drive and enable, bits 7-6 idle
    input wire logic [7:0] port_e_pin_in, // Port E pins, shared with analog inputs
    input wire logic [7:0] port_f_pin_in, // Port F pin levels
    output pin_drive_t port_f_pin_out, // Port F drive and enable
    input wire logic [7:0] port_g_pin_in, // Port G pin levels
    output pin_drive_t port_g_pin_out // Port G drive and enable
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Register index of a byte address, or all ones when not word aligned.
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
        if (addr[1:0] != 2'h0)
        begin
            return 8'hff;
        end
        return {2'h0, addr[ADDR_W-1:2]};
    endfunction

    // Output pins read back their data bit, input pins the pin level.
    function automatic logic [7:0] readback(input logic [7:0] dir,
                                            input logic [7:0] data,
                                            input logic [7:0] pin);
        return (dir & data) | (~dir & pin);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] b_dir_reg, c_dir_reg, d_dir_reg, f_dir_reg;
    logic [7:0] b_data_reg, c_data_reg, d_data_reg, f_data_reg;
    logic [7:0] mode_reg;
    logic expanded;
    logic aw_held_reg, w_held_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic w_lane_reg;
    logic do_write;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] rd_idx;
    logic [7:0] rd_value;
    logic rd_hit;
    rd_state_t rd_state_reg;

    assign expanded = mode_reg[MODE_EXPANDED_BIT];

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are taken in either order; the write happens once both are held.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= '0;
        end
        else if (do_write)
        begin
            aw_held_reg <= 1'b0;
        end
        else if (awvalid_in && awready_out)
        begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= awaddr_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end
        else if (do_write)
        begin
            w_held_reg <= 1'b0;
        end
        else if (wvalid_in && wready_out)
        begin
            w_held_reg <= 1'b1;
            w_data_reg <= wdata_in[7:0];
            w_lane_reg <= wstrb_in[0];
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            awready_out <= 1'b0;
            wready_out <= 1'b0;
        end
        else
        begin
            awready_out <= !aw_held_reg && !(awvalid_in && awready_out) && !bvalid_out;
            wready_out <= !w_held_reg && !(wvalid_in && wready_out) && !bvalid_out;
        end
    end

    assign do_write = aw_held_reg && w_held_reg && !bvalid_out;
    assign wr_idx = reg_index(aw_addr_reg);

    // Ports B, C and F vanish from the map in expanded operation.
    always_comb
    begin
        wr_hit = 1'b1;
        if (wr_idx == IDX_MODE_CONTROL || wr_idx == IDX_PORT_D_DATA
            || wr_idx == IDX_PORT_D_DIRECTION || wr_idx == IDX_PORT_E_INPUT)
        begin
            wr_hit = 1'b1;
        end
        else if (wr_idx == IDX_PORT_B_DATA || wr_idx == IDX_PORT_B_DIRECTION
                 || wr_idx == IDX_PORT_C_DATA || wr_idx == IDX_PORT_C_DIRECTION
                 || wr_idx == IDX_PORT_F_DATA || wr_idx == IDX_PORT_F_DIRECTION)
        begin
            wr_hit = !expanded;
        end
        else
        begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            bvalid_out <= 1'b0;
            bresp_out <= RESP_OKAY;
        end
        else if (do_write)
        begin
            bvalid_out <= 1'b1;
            bresp_out <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (bready_in)
        begin
            bvalid_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Direction and mode registers clear on reset.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            b_dir_reg <= DIR_RESET;
            c_dir_reg <= DIR_RESET;
            d_dir_reg <= DIR_RESET;
            f_dir_reg <= DIR_RESET;
            mode_reg <= MODE_RESET;
        end
        else if (do_write && wr_hit && w_lane_reg)
        begin
            if (wr_idx == IDX_PORT_B_DIRECTION)
            begin
                b_dir_reg <= w_data_reg;
            end
            else if (wr_idx == IDX_PORT_C_DIRECTION)
            begin
                c_dir_reg <= w_data_reg;
            end
            else if (wr_idx == IDX_PORT_D_DIRECTION)
            begin
                d_dir_reg <= w_data_reg & PORT_D_MASK;
            end
            else if (wr_idx == IDX_PORT_F_DIRECTION)
            begin
                f_dir_reg <= w_data_reg;
            end
            else if (wr_idx == IDX_MODE_CONTROL)
            begin
                mode_reg <= {7'h00, w_data_reg[MODE_EXPANDED_BIT]};
            end
        end
    end

    // Data registers have no reset, so their contents survive a reset.
    always_ff @(posedge clock_in)
    begin
        if (do_write && wr_hit && w_lane_reg)
        begin
            if (wr_idx == IDX_PORT_B_DATA)
            begin
                b_data_reg <= w_data_reg;
            end
            else if (wr_idx == IDX_PORT_C_DATA)
            begin
                c_data_reg <= w_data_reg;
            end
            else if (wr_idx == IDX_PORT_D_DATA)
            begin
                d_data_reg <= w_data_reg & PORT_D_MASK;
            end
            else if (wr_idx == IDX_PORT_F_DATA)
            begin
                f_data_reg <= w_data_reg;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign rd_idx = reg_index(araddr_in);

    always_comb
    begin
        rd_value = 8'h00;
        rd_hit = 1'b1;
        if (rd_idx == IDX_MODE_CONTROL)
        begin
            rd_value = mode_reg;
        end
        else if (rd_idx == IDX_PORT_D_DATA)
        begin
            rd_value = readback(d_dir_reg, d_data_reg, {2'h0, port_d_pin_in});
        end
        else if (rd_idx == IDX_PORT_D_DIRECTION)
        begin
            rd_value = d_dir_reg;
        end
        else if (rd_idx == IDX_PORT_E_INPUT)
        begin
            // A read here can upset an analog sample; software must time it.
            rd_value = port_e_pin_in;
        end
        else if (expanded)
        begin
            rd_hit = 1'b0;
        end
        else if (rd_idx == IDX_PORT_B_DATA)
        begin
            rd_value = readback(b_dir_reg, b_data_reg, port_b_pin_in);
        end
        else if (rd_idx == IDX_PORT_B_DIRECTION)
        begin
            rd_value = b_dir_reg;
        end
        else if (rd_idx == IDX_PORT_C_DATA)
        begin
            rd_value = readback(c_dir_reg, c_data_reg, port_c_pin_in);
        end
        else if (rd_idx == IDX_PORT_C_DIRECTION)
        begin
            rd_value = c_dir_reg;
        end
        else if (rd_idx == IDX_PORT_F_DATA)
        begin
            rd_value = readback(f_dir_reg, f_data_reg, port_f_pin_in);
        end
        else if (rd_idx == IDX_PORT_F_DIRECTION)
        begin
            rd_value = f_dir_reg;
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // One read at a time: the address is taken, and the data follow one cycle later.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_state_reg <= RD_IDLE;
            arready_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= RESP_OKAY;
        end
        else
        begin
            case (rd_state_reg)
                RD_IDLE:
                begin
                    arready_out <= 1'b1;
                    if (arvalid_in && arready_out)
                    begin
                        arready_out <= 1'b0;
                        rvalid_out <= 1'b1;
                        rdata_out <= {24'h00_0000, rd_value};
                        rresp_out <= rd_hit ? RESP_OKAY : RESP_DECERR;
                        rd_state_reg <= RD_RESP;
                    end
                end
                RD_RESP:
                begin
                    if (rready_in)
                    begin
                        rvalid_out <= 1'b0;
                        rd_state_reg <= RD_IDLE;
                    end
                end
                default:
                begin
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drive
    // ----------------------------------------------------------------
    // Drive levels are registered so every pin output comes from a flip-flop.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            port_b_pin_out <= '0;
            port_c_pin_out <= '0;
            port_d_pin_out <= '0;
            port_f_pin_out <= '0;
            port_g_pin_out <= '0;
        end
        else
        begin
            if (expanded)
            begin
                port_b_pin_out <= '{level: ext_addr_in[15:8], enable: 8'hff};
                port_c_pin_out <= '{level: ext_wdata_in, enable: {8{ext_data_drive_in}}};
                port_f_pin_out <= '{level: ext_addr_in[7:0], enable: 8'hff};
            end
            else
            begin
                port_b_pin_out <= '{level: b_data_reg, enable: b_dir_reg};
                port_c_pin_out <= '{level: c_data_reg, enable: c_dir_reg};
                port_f_pin_out <= '{level: f_data_reg, enable: f_dir_reg};
            end
            // Alternate functions take the pin; the data bit then has no effect.
            port_d_pin_out.level <= {2'h0, (d_alt_sel_in & d_alt_level_in)
                                     | (~d_alt_sel_in & d_data_reg[5:0])};
            port_d_pin_out.enable <= {2'h0, (d_alt_sel_in & d_alt_enable_in)
                                      | (~d_alt_sel_in & d_dir_reg[5:0])};
            // Port G has no registers here; idle pins stay inputs.
            port_g_pin_out.level <= {ext_rw_in, g_alt_sel_in & g_alt_level_in};
            port_g_pin_out.enable <= {expanded, g_alt_sel_in & g_alt_enable_in};
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            ext_rdata_out <= 8'h00;
            pin_level_out <= 8'h00;
        end
        else
        begin
            ext_rdata_out <= port_c_pin_in;
            pin_level_out <= {port_g_pin_in[1:0], port_d_pin_in};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_dir_reset_clear: assert property (@(posedge clock_in)
        $rose(rst_b_in) |-> (b_dir_reg == 8'h00 && c_dir_reg == 8'h00
                             && d_dir_reg == 8'h00 && f_dir_reg == 8'h00))
        else $error("direction register not clear after reset");

    a_c_output_drive: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        !expanded |=> port_c_pin_out.enable == $past(c_dir_reg))
        else $error("port C enable does not follow direction");

    a_c_data_bus: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        expanded |=> port_c_pin_out.level == $past(ext_wdata_in))
        else $error("port C does not carry the data bus");

    a_f_low_addr: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        expanded |=> port_f_pin_out.enable == 8'hff
                     && port_f_pin_out.level == $past(ext_addr_in[7:0]))
        else $error("port F does not carry the low address");

    a_d_upper_zero: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (arvalid_in && arready_out
         && (rd_idx == IDX_PORT_D_DATA || rd_idx == IDX_PORT_D_DIRECTION))
        |=> rvalid_out && rdata_out[7:6] == 2'h0 && port_d_pin_out.enable[7:6] == 2'h0)
        else $error("port D upper bits not zero");

    a_d_alt_owns: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        d_alt_sel_in != 6'h00 |=>
            (port_d_pin_out.level[5:0] & $past(d_alt_sel_in))
            == ($past(d_alt_sel_in) & $past(d_alt_level_in)))
        else $error("port D data write reached an alternate pin");

    a_g_top_pin: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        ##1 port_g_pin_out.enable[7] == $past(expanded))
        else $error("port G top pin drive wrong for mode");

    a_hidden_decerr: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (arvalid_in && arready_out && expanded && araddr_in == 8'h18)
        |=> rvalid_out && rresp_out == RESP_DECERR)
        else $error("hidden port C register answered");

    a_e_readonly: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        (arvalid_in && arready_out && araddr_in == 8'h28)
        |=> rvalid_out && rdata_out[7:0] == $past(port_e_pin_in))
        else $error("port E read does not show the pins");

    a_write_resp: assert property (@(posedge clock_in) disable iff (!rst_b_in)
        do_write |=> bvalid_out)
        else $error("write not answered");

endmodule

/* tb/pin_world.sv */
// Outside circuitry seen by one port: resolves each pin from device drive and outside level.
`timescale 1ns/100ps
module pin_world
    import parallel_port_pkg::*;
(
    input wire pin_drive_t drive_in, // Device drive and enable
    input wire logic [7:0] outside_in, // Level the outside circuit puts on the pin
    output logic [7:0] pin_out // Resolved pin level
);
    // A released pin shows the outside level, never the device's last value.
    assign pin_out = (drive_in.enable & drive_in.level) | (~drive_in.enable & outside_in);
endmodule

/* tb/parallel_port_group_bench.sv */
// Self-checking bench for the parallel port group.
`timescale 1ns/100ps
module parallel_port_group_bench import parallel_port_pkg::*;;
    logic clock_in, rst_b_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic ext_data_drive_in, ext_rw_in;
    logic [1:0] bresp_out, rresp_out;
    logic [3:0] wstrb_in;
    logic [5:0] d_alt_sel_in, d_alt_level_in, d_alt_enable_in;
    logic [6:0] g_alt_sel_in, g_alt_level_in, g_alt_enable_in;
    logic [7:0] awaddr_in, araddr_in, ext_wdata_in, ext_rdata_out, pin_level_out, outside, port_e;
    logic [7:0] pins_b, pins_c, pins_d, pins_f, pins_g;
    logic [15:0] ext_addr_in;
    logic [31:0] wdata_in, rdata_out;
    logic [7:0] dir_addr [4] = '{8'h08, 8'h0c, 8'h1c, 8'h24};
    pin_drive_t pb, pc, pd, pf, pg;
    int miscompares = 0;
    int checked = 0;

    parallel_port_group uut (.clock_in, .rst_b_in, .awvalid_in, .awready_out, .awaddr_in,
        .wvalid_in, .wready_out, .wdata_in, .wstrb_in, .bvalid_out, .bready_in, .bresp_out,
        .arvalid_in, .arready_out, .araddr_in, .rvalid_out, .rready_in, .rdata_out, .rresp_out,
        .ext_addr_in, .ext_wdata_in, .ext_data_drive_in, .ext_rw_in, .ext_rdata_out,
        .d_alt_sel_in, .d_alt_level_in, .d_alt_enable_in, .g_alt_sel_in, .g_alt_level_in,
        .g_alt_enable_in, .pin_level_out, .port_b_pin_in(pins_b), .port_b_pin_out(pb),
        .port_c_pin_in(pins_c), .port_c_pin_out(pc), .port_d_pin_in(pins_d[5:0]),
        .port_d_pin_out(pd), .port_e_pin_in(port_e), .port_f_pin_in(pins_f),
        .port_f_pin_out(pf), .port_g_pin_in(pins_g), .port_g_pin_out(pg));
    pin_world wb (.drive_in(pb), .outside_in(outside), .pin_out(pins_b));
    pin_world wc (.drive_in(pc), .outside_in(outside), .pin_out(pins_c));
    pin_world wd (.drive_in(pd), .outside_in(outside), .pin_out(pins_d));
    pin_world wf (.drive_in(pf), .outside_in(outside), .pin_out(pins_f));
    pin_world wg (.drive_in(pg), .outside_in(outside), .pin_out(pins_g));

    // ----------------------------------------------------------------
    // Bus, check, reset and report tasks
    // ----------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Ready is registered, so its value at the falling edge is the one the next rising edge sees.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_go, w_go, b_go;
        logic [1:0] resp;
        awvalid_in <= 1'b1;
        awaddr_in <= a;
        wvalid_in <= 1'b1;
        wdata_in <= {24'h0, d};
        bready_in <= 1'b1;
        do
        begin
            @(negedge clock_in);
            aw_go = awvalid_in & awready_out;
            w_go = wvalid_in & wready_out;
            b_go = bvalid_out;
            resp = bresp_out;
            @(posedge clock_in);
            if (aw_go) awvalid_in <= 1'b0;
            if (w_go) wvalid_in <= 1'b0;
        end
        while (b_go !== 1'b1);
        bready_in <= 1'b0;
        chk("write response", {6'h0, er}, {6'h0, resp});
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] er);
        logic ar_go, r_go;
        logic [7:0] d;
        logic [1:0] resp;
        arvalid_in <= 1'b1;
        araddr_in <= a;
        rready_in <= 1'b1;
        do
        begin
            @(negedge clock_in);
            ar_go = arvalid_in & arready_out;
            r_go = rvalid_out;
            d = rdata_out[7:0];
            resp = rresp_out;
            @(posedge clock_in);
            if (ar_go) arvalid_in <= 1'b0;
        end
        while (r_go !== 1'b1);
        rready_in <= 1'b0;
        chk("read data", exp, d);
        chk("read response", {6'h0, er}, {6'h0, resp});
        @(posedge clock_in);
    endtask

    task automatic pulse_reset();
        rst_b_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        rst_b_in <= 1'b1;
        repeat (2) @(posedge clock_in);
    endtask

    task automatic final_report();
        if (miscompares == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end

    initial
    begin
        #200000;
        miscompares++;
        final_report();
    end

    initial
    begin
        {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in, ext_data_drive_in} = 6'h0;
        {awaddr_in, araddr_in, wdata_in, wstrb_in} = 52'hf;
        {ext_addr_in, ext_wdata_in, ext_rw_in} = {16'h3c81, 8'h6e, 1'b1};
        {d_alt_sel_in, d_alt_level_in, d_alt_enable_in} = 18'h0;
        {g_alt_sel_in, g_alt_level_in, g_alt_enable_in} = 21'h0;
        outside = 8'h5a;
        port_e = 8'ha5;
        rst_b_in = 1'b0;
        pulse_reset();
        chk("reset drive", 8'h00, pb.enable | pc.enable | pd.enable | pf.enable | pg.enable);
        foreach (dir_addr[i]) rd(dir_addr[i], 8'h00, RESP_OKAY);
        rd(8'h18, 8'h5a, RESP_OKAY);
        wr(8'h18, 8'h3c, RESP_OKAY);
        wr(8'h1c, 8'h0f, RESP_OKAY);
        rd(8'h18, 8'h5c, RESP_OKAY);
        chk("port c drive", 8'h0f, pc.enable);
        chk("port c level", 8'h0c, pc.level & pc.enable);
        wstrb_in <= 4'he;
        wr(8'h1c, 8'hff, RESP_OKAY);
        wstrb_in <= 4'hf;
        rd(8'h1c, 8'h0f, RESP_OKAY);
        wr(8'h24, 8'hff, RESP_OKAY);
        rd(8'h24, 8'h3f, RESP_OKAY);
        d_alt_sel_in <= 6'h03;
        d_alt_enable_in <= 6'h03;
        d_alt_level_in <= 6'h01;
        wr(8'h20, 8'hff, RESP_OKAY);
        rd(8'h20, 8'h3f, RESP_OKAY);
        chk("port d level", 8'h3d, pd.level);
        chk("port d drive", 8'h3f, pd.enable);
        rd(8'h28, 8'ha5, RESP_OKAY);
        wr(8'h28, 8'h00, RESP_OKAY);
        rd(8'h28, 8'ha5, RESP_OKAY);
        rd(8'h30, 8'h00, RESP_DECERR);
        wr(8'h30, 8'h11, RESP_DECERR);
        rd(8'h19, 8'h00, RESP_DECERR);
        rd(8'h10, 8'h5a, RESP_OKAY);
        wr(8'h0c, 8'hff, RESP_OKAY);
        wr(8'h14, 8'h96, RESP_OKAY);
        chk("port f level", 8'h96, pf.level);
        pulse_reset();
        chk("port f drive", 8'h00, pf.enable);
        wr(8'h0c, 8'hff, RESP_OKAY);
        rd(8'h14, 8'h96, RESP_OKAY);
        g_alt_sel_in <= 7'h7f;
        g_alt_enable_in <= 7'h7f;
        g_alt_level_in <= 7'h55;
        wr(8'h2c, 8'h01, RESP_OKAY);
        chk("port g drive", 8'hff, pg.enable);
        chk("port g level", 8'hd5, pg.level);
        rd(8'h18, 8'h00, RESP_DECERR);
        wr(8'h14, 8'h00, RESP_DECERR);
        chk("port f address", 8'h81, pf.level);
        chk("port f drive", 8'hff, pf.enable);
        ext_data_drive_in <= 1'b1;
        repeat (2) @(negedge clock_in);
        chk("data bus out", 8'h6e, pc.level & pc.enable);
        @(posedge clock_in);
        ext_data_drive_in <= 1'b0;
        repeat (3) @(negedge clock_in);
        chk("data bus in", 8'h5a, ext_rdata_out);
        chk("data bus drive", 8'h00, pc.enable);
        chk("pin levels", 8'h59, pin_level_out);
        final_report();
    end
endmodule
